// ### logic/out_cfg_pkg.sv
// Package: register map, field layout and types of the output config bank
package out_cfg_pkg;

  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_ROUTING = 8'h64;
  localparam logic [7:0] IDX_POS     = 8'h65;
  localparam logic [7:0] IDX_NEG     = 8'h66;
  // Word index field of the byte address
  localparam int         ADDR_LSB    = 2;
  localparam int         IDX_W       = 8;

  // Reset values
  localparam logic [7:0] RST_ROUTING = 8'h20;
  localparam logic [7:0] RST_POS     = 8'h20;
  localparam logic [7:0] RST_NEG     = 8'h20;

  // Field positions, routing register
  localparam int SRC_LSB   = 5;
  localparam int ROUTE_LSB = 2;
  localparam int VCOM_BIT  = 1;
  localparam int LP_BIT    = 0;
  // Field positions, driver registers
  localparam int DRV_LSB   = 6;
  localparam int LVL_LSB   = 3;
  localparam int BW_BIT    = 0;
  localparam int FS_BIT    = 1;
  localparam int CMT_BIT   = 0;

  // Writable-bit masks; all other bits are reserved, read zero
  localparam logic [7:0] MASK_ROUTING = 8'hFF;
  localparam logic [7:0] MASK_POS     = 8'hF9;
  localparam logic [7:0] MASK_NEG     = 8'hFB;

  // Codes that matter to derived controls
  localparam logic [2:0] SRC_CONV     = 3'h1;
  localparam logic [2:0] ROUTE_STEREO = 3'h1;
  localparam logic [2:0] LVL_MIN_OK   = 3'h4;

  // Driver type codes
  typedef enum logic [1:0] {
    DRV_LINE, DRV_HEADPHONE, DRV_FOUR_OHM, DRV_RECEIVER
  } drv_type_e;

  // Controls handed to the analog side
  typedef struct packed {
    logic [2:0] output_source_sel;
    logic [2:0] output_routing_sel;
    logic       output_common_mode_sel;
    logic       output_low_power;
    drv_type_e  pos_driver_type;
    logic [2:0] pos_level_ctrl;
    logic       conv_bandwidth_sel;
    drv_type_e  neg_driver_type;
    logic [2:0] neg_level_ctrl;
    logic       conv_fullscale_sel;
    logic       input_cm_tolerance_sel;
  } ana_ctrl_s;

  // AHB transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// ### logic/cfg_reg8.sv
// Module: one 8-bit configuration register with a reserved-bit mask
`timescale 1ns/1ps
module cfg_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic      [7:0] value_q
);

  // Only writable bits change; reserved bits stay at reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_q <= RESET_VAL;
    end else if (wr_en) begin
      value_q <= (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

endmodule // cfg_reg8

// ### logic/output_driver_config_regs.sv
// Module: output driver configuration register bank on AHB-Lite
`timescale 1ns/1ps

// How it works
// - Routing bit 1 picks common mode: 0 = 0.6 Vref, 1 = half supply.
// - Routing bit 0 low power works for converter source, not stereo SE.
// - The positive driver register sits at index 0x65 and resets to 0x20.
// - The negative driver register sits at index 0x66 and resets to 0x20.
// - Positive bits 7-6 pick the positive driver type, reset line.
// - Positive bits 5-3 set attenuation, codes 4-7 only (codes 0-3 are stored as written and raise level_code_err), reset 4.
// - Positive bit 0 picks converter bandwidth, 0 = 24 kHz, 1 = 96 kHz.
// - Negative bits 7-6 pick the negative driver type, same codes.
// - Negative bits 5-3 set attenuation, codes 4-7 only (codes 0-3 are stored as written and raise level_code_err), reset 4.
// - Negative bit 1 picks full scale, 0 = 10 Vrms, 1 = 5 Vrms.
// - Negative bit 0 picks the input common-mode tolerance range.
// - Reserved bits read zero, ignore writes; software writes them zero.
// - Routing register: index 0x64, reset 0x20, source 7-5, route 4-2.
module output_driver_config_regs (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Controls to the analog outputs
  output out_cfg_pkg::ana_ctrl_s      ana_ctrl,
  // Attenuation code outside the legal range was written
  output logic                        level_code_err
);

  // Address-phase capture, stored registers, read mux, write strobes, low-power gate
  logic                               wr_pend_q;
  logic [out_cfg_pkg::IDX_W-1:0]      wr_idx_q;
  logic                               rd_take;
  logic                               access;
  logic [out_cfg_pkg::IDX_W-1:0]      a_idx;
  logic [7:0]                         routing_q;
  logic [7:0]                         pos_q;
  logic [7:0]                         neg_q;
  logic [7:0]                         rd_mux;
  logic                               wr_routing;
  logic                               wr_pos;
  logic                               wr_neg;
  logic                               lp_allowed;
  // Register contents as they stand after the current edge
  logic [7:0]                         routing_d;
  logic [7:0]                         pos_d;
  logic [7:0]                         neg_d;
  // Read address decode
  logic                               rd_hit_routing;
  logic                               rd_hit_pos;
  logic                               rd_hit_neg;
  // Stored fields, routing register
  logic [2:0]                         src_sel;
  logic [2:0]                         route_sel;
  logic                               vcom_sel;
  logic                               lp_req;
  logic                               lp_src_ok;
  logic                               lp_route_ok;
  // Stored fields, positive driver register
  logic [1:0]                         pos_drv;
  logic [2:0]                         pos_lvl;
  logic                               bw_sel;
  logic                               pos_lvl_bad;
  // Stored fields, negative driver register
  logic [1:0]                         neg_drv;
  logic [2:0]                         neg_lvl;
  logic                               fs_sel;
  logic                               cmt_sel;
  logic                               neg_lvl_bad;

  assign access = hsel & hready & (htrans == out_cfg_pkg::HTRANS_NONSEQ
                  || htrans == out_cfg_pkg::HTRANS_SEQ);
  assign a_idx  = haddr[out_cfg_pkg::ADDR_LSB +: out_cfg_pkg::IDX_W];

  // Latch address phase of writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= '0;
    end else begin
      wr_pend_q <= access & hwrite;
      if (access & hwrite) begin
        wr_idx_q <= a_idx;
      end
    end
  end

  // Reads are answered from their address phase, data loaded at its edge
  assign rd_take = access & ~hwrite;

  // Write strobes in the data phase
  assign wr_routing = wr_pend_q &
                      (wr_idx_q == out_cfg_pkg::IDX_ROUTING);
  assign wr_pos     = wr_pend_q &
                      (wr_idx_q == out_cfg_pkg::IDX_POS);
  assign wr_neg     = wr_pend_q &
                      (wr_idx_q == out_cfg_pkg::IDX_NEG);

  // Routing register after this edge; a write in its data phase is
  // passed through so a read right behind it sees the new contents
  always_comb begin
    routing_d = routing_q;
    if (wr_routing) begin
      routing_d = (hwdata[7:0] & out_cfg_pkg::MASK_ROUTING) |
        (out_cfg_pkg::RST_ROUTING & ~out_cfg_pkg::MASK_ROUTING);
    end
  end

  // Positive driver register after this edge, reserved bits kept
  always_comb begin
    pos_d = pos_q;
    if (wr_pos) begin
      pos_d = (hwdata[7:0] & out_cfg_pkg::MASK_POS) |
        (out_cfg_pkg::RST_POS & ~out_cfg_pkg::MASK_POS);
    end
  end

  // Negative driver register after this edge, reserved bit kept
  always_comb begin
    neg_d = neg_q;
    if (wr_neg) begin
      neg_d = (hwdata[7:0] & out_cfg_pkg::MASK_NEG) |
        (out_cfg_pkg::RST_NEG & ~out_cfg_pkg::MASK_NEG);
    end
  end

  // Routing register: source, routing, common mode, low power
  cfg_reg8 #(
    .RESET_VAL (out_cfg_pkg::RST_ROUTING),
    .WR_MASK   (out_cfg_pkg::MASK_ROUTING)
  ) u_routing (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_routing),
    .wr_data (hwdata[7:0]),
    .value_q (routing_q)
  );

  // Positive driver register, bits 2-1 reserved
  cfg_reg8 #(
    .RESET_VAL (out_cfg_pkg::RST_POS),
    .WR_MASK   (out_cfg_pkg::MASK_POS)
  ) u_pos (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_pos),
    .wr_data (hwdata[7:0]),
    .value_q (pos_q)
  );

  // Negative driver register, bit 2 reserved
  cfg_reg8 #(
    .RESET_VAL (out_cfg_pkg::RST_NEG),
    .WR_MASK   (out_cfg_pkg::MASK_NEG)
  ) u_neg (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_neg),
    .wr_data (hwdata[7:0]),
    .value_q (neg_q)
  );

  // Read address decode on the index of the address phase
  assign rd_hit_routing = (a_idx == out_cfg_pkg::IDX_ROUTING);
  assign rd_hit_pos     = (a_idx == out_cfg_pkg::IDX_POS);
  assign rd_hit_neg     = (a_idx == out_cfg_pkg::IDX_NEG);

  // Read mux; unmapped indices and reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (rd_hit_routing) begin
      rd_mux = routing_d;
    end else if (rd_hit_pos) begin
      rd_mux = pos_d & out_cfg_pkg::MASK_POS;
    end else if (rd_hit_neg) begin
      rd_mux = neg_d & out_cfg_pkg::MASK_NEG;
    end
  end

  // Read data loaded at the address phase edge, so that it stands for
  // the whole data phase and is held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // Zero-wait responses, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Stored fields of the routing register
  assign src_sel   = routing_q[out_cfg_pkg::SRC_LSB +: 3];
  assign route_sel = routing_q[out_cfg_pkg::ROUTE_LSB +: 3];
  assign vcom_sel  = routing_q[out_cfg_pkg::VCOM_BIT];
  assign lp_req    = routing_q[out_cfg_pkg::LP_BIT];

  // Stored fields of the positive driver register
  assign pos_drv = pos_q[out_cfg_pkg::DRV_LSB +: 2];
  assign pos_lvl = pos_q[out_cfg_pkg::LVL_LSB +: 3];
  assign bw_sel  = pos_q[out_cfg_pkg::BW_BIT];

  // Stored fields of the negative driver register
  assign neg_drv = neg_q[out_cfg_pkg::DRV_LSB +: 2];
  assign neg_lvl = neg_q[out_cfg_pkg::LVL_LSB +: 3];
  assign fs_sel  = neg_q[out_cfg_pkg::FS_BIT];
  assign cmt_sel = neg_q[out_cfg_pkg::CMT_BIT];

  // Low power is refused unless the converter feeds the output and the
  // routing is not stereo single-ended
  assign lp_src_ok   = (src_sel == out_cfg_pkg::SRC_CONV);
  assign lp_route_ok = (route_sel != out_cfg_pkg::ROUTE_STEREO);
  assign lp_allowed  = lp_src_ok & lp_route_ok;

  // Attenuation codes below the legal range; stored as written
  assign pos_lvl_bad = (pos_lvl < out_cfg_pkg::LVL_MIN_OK);
  assign neg_lvl_bad = (neg_lvl < out_cfg_pkg::LVL_MIN_OK);

  // Decoded controls registered onto the analog side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_ctrl <= '0;
    end else begin
      ana_ctrl.output_source_sel      <= src_sel;
      ana_ctrl.output_routing_sel     <= route_sel;
      ana_ctrl.output_common_mode_sel <= vcom_sel;
      ana_ctrl.output_low_power       <= lp_req & lp_allowed;
      ana_ctrl.pos_driver_type        <=
        out_cfg_pkg::drv_type_e'(pos_drv);
      ana_ctrl.pos_level_ctrl         <= pos_lvl;
      ana_ctrl.conv_bandwidth_sel     <= bw_sel;
      ana_ctrl.neg_driver_type        <=
        out_cfg_pkg::drv_type_e'(neg_drv);
      ana_ctrl.neg_level_ctrl         <= neg_lvl;
      ana_ctrl.conv_fullscale_sel     <= fs_sel;
      ana_ctrl.input_cm_tolerance_sel <= cmt_sel;
    end
  end

  // Flag a stored attenuation code below the legal range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_code_err <= 1'b0;
    end else begin
      level_code_err <= pos_lvl_bad | neg_lvl_bad;
    end
  end

endmodule // output_driver_config_regs

// ### verif/out_cfg_monitor.sv
// Checker: bus and control-output relations of the config bank
`timescale 1ns/1ps
module out_cfg_monitor (
  // Clock, reset and bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // Responses and controls
  input wire logic        hreadyout, hresp, level_code_err,
  input wire out_cfg_pkg::ana_ctrl_s ana_ctrl
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase of a write, then its data phase
  sequence wr_to(a);
    hsel && hready && htrans[1] && hwrite && haddr == a ##1 1'b1;
  endsequence
  AST_READY: assert property (hreadyout)
    else $error("hreadyout low");
  AST_RESP: assert property (!hresp)
    else $error("hresp not okay");
  AST_UPPER: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_POS_WR: assert property (wr_to(32'h194) |-> ##2
    {ana_ctrl.pos_driver_type, ana_ctrl.pos_level_ctrl,
     ana_ctrl.conv_bandwidth_sel} == {$past(hwdata[7:3], 2),
     $past(hwdata[0], 2)}) else $error("pos controls differ from write");
  AST_NEG_WR: assert property (wr_to(32'h198) |-> ##2
    {ana_ctrl.neg_driver_type, ana_ctrl.neg_level_ctrl,
     ana_ctrl.conv_fullscale_sel, ana_ctrl.input_cm_tolerance_sel} ==
    {$past(hwdata[7:3], 2), $past(hwdata[1:0], 2)})
    else $error("neg controls differ from write");
  AST_ROUTE_WR: assert property (wr_to(32'h190) |-> ##2
    {ana_ctrl.output_source_sel, ana_ctrl.output_routing_sel,
     ana_ctrl.output_common_mode_sel} == $past(hwdata[7:1], 2))
    else $error("routing controls differ from write");
  AST_LOWPWR: assert property (wr_to(32'h190) |-> ##2
    ana_ctrl.output_low_power == ($past(hwdata[0], 2) &&
    $past(hwdata[7:5], 2) == 3'h1 && $past(hwdata[4:2], 2) != 3'h1))
    else $error("low power gating wrong");
  AST_LVL_ERR: assert property ($past(hresetn) |->
    level_code_err == (ana_ctrl.pos_level_ctrl < 3'h4 ||
    ana_ctrl.neg_level_ctrl < 3'h4)) else $error("level flag wrong");
endmodule // out_cfg_monitor

bind output_driver_config_regs out_cfg_monitor u_mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .level_code_err(level_code_err),
  .ana_ctrl(ana_ctrl));

// ### verif/tb_top.sv
// Testbench: bus access and control outputs of the output config bank
`timescale 1ns/1ps
module tb_top;
  logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp, err;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [7:0]             d, e;
  logic [7:0]             rte_vals [4] = '{8'h25, 8'h21, 8'h01, 8'h33};
  out_cfg_pkg::ana_ctrl_s ana;
  int                     fails, cmp_count;
  // Control outputs packed back into register layout
  wire [7:0] rte = {ana.output_source_sel, ana.output_routing_sel,
                    ana.output_common_mode_sel, ana.output_low_power};
  wire [7:0] pos = {ana.pos_driver_type, ana.pos_level_ctrl, 2'h0,
                    ana.conv_bandwidth_sel};
  wire [7:0] neg = {ana.neg_driver_type, ana.neg_level_ctrl, 1'h0,
                    ana.conv_fullscale_sel, ana.input_cm_tolerance_sel};
  output_driver_config_regs u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ana_ctrl(ana),
    .level_code_err(err));
  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    for (int n = 0; n < 16; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    fails++;
    final_report();
  endtask
  // One single AHB transfer; read data taken at the data-phase edge
  task automatic xfer(logic w, logic [31:0] a, logic [7:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= out_cfg_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    wait_rdy();
    rd = hrdata;
  endtask
  // Write then read of one word, pipelined with no idle cycle between
  task automatic wr_rd(logic [31:0] a, logic [7:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= out_cfg_pkg::HTRANS_NONSEQ;
    wait_rdy();
    hwrite <= 1'b0;
    hwdata <= {24'h0, v};
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(logic [31:0] a, logic [7:0] e);
    xfer(1'b0, a, 8'h0);
    chk("hrdata", e, rd[7:0]);
  endtask
  // Let the control outputs follow the last write
  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask
  // Reset for six cycles, then check reset values everywhere
  task automatic reset_chk();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("rte", 8'h20, rte);
    chk("pos", 8'h20, pos);
    chk("neg", 8'h20, neg);
    chk("err", 8'h0, {7'h0, err});
    rchk(32'h190, 8'h20);
    rchk(32'h194, 8'h20);
    rchk(32'h198, 8'h20);
    $display("Reset test done");
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    fails = 0;
    cmp_count = 0;
    reset_chk();
    // Every driver code and legal level, reserved bits kept at zero
    for (int k = 0; k < 4; k++) begin
      d = {k[1:0], 1'b1, k[1:0], 2'h0, k[0]};
      e = {d[7:3], 1'b0, k[1:0]};
      xfer(1'b1, 32'h194, d);
      xfer(1'b1, 32'h198, e);
      rchk(32'h194, d);
      rchk(32'h198, e);
      settle();
      chk("pos", d, pos);
      chk("neg", e, neg);
      chk("err", 8'h0, {7'h0, err});
    end
    $display("Driver field test done");
    // Forbidden level codes flag an error until repaired
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, (k[0] ? 32'h198 : 32'h194), {2'h0, k[2:0], 3'h0});
      settle();
      chk("err", 8'h1, {7'h0, err});
      xfer(1'b1, (k[0] ? 32'h198 : 32'h194), 8'h20);
      settle();
      chk("err", 8'h0, {7'h0, err});
    end
    $display("Level code test done");
    // Low power honoured only for converter source, not stereo routing
    foreach (rte_vals[i]) begin
      d = rte_vals[i];
      xfer(1'b1, 32'h190, d);
      rchk(32'h190, d);
      settle();
      chk("rte", {d[7:1], d[0] && d[7:5] == 3'h1 && d[4:2] != 3'h1},
          rte);
    end
    $display("Routing test done");
    // Unmapped word ignores writes and reads zero
    xfer(1'b1, 32'h19C, 8'hFF);
    rchk(32'h19C, 8'h00);
    rchk(32'h198, 8'h20);
    $display("Unmapped test done");
    // Read right behind a write of the same word sees the new value
    wr_rd(32'h194, 8'h39);
    chk("hrdata", 8'h39, rd[7:0]);
    settle();
    chk("pos", 8'h39, pos);
    $display("Back-to-back test done");
    reset_chk();
    final_report();
  end
endmodule // tb_top
